// >>> core/pixel_matrix_readout_sequencer.sv
// What this block does
// - Start on internal falling edge after sync
// - Marker flags first pixel of frame
// - Frames repeat continuously until clock stops
// - Sync reissue restarts from frame start
// - Ten subframes, 320 by 64, scanned together
// - Scan upper left to lower right
// - Two programmable marker pixels per row
// - Two banks, each own serial output
// - Reset on power-on or reset pad
// - Marker defaults hold only during reset; pin levels take over after
// - Eight-bit test converter, word per 10 us
`timescale 1ns/1ns
`default_nettype none
module pixel_matrix_readout_sequencer
	import readout_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic reset_pad_n,
	input wire logic por_n,
	input wire logic sync_in,
	input wire logic [PIX_W-1:0] mark0_level,
	input wire logic [PIX_W-1:0] mark1_level,
	input wire logic [SUBFRAMES*PIX_W-1:0] pixel_in,
	input wire logic [ADC_W-1:0] adc_in,
	output logic [8:0] row_addr,
	output logic [5:0] col_addr,
	output logic [PIX_W-1:0] bank0_data,
	output logic [PIX_W-1:0] bank1_data,
	output logic [2:0] bank_slot,
	output logic first_pixel_marker,
	output logic data_valid,
	input wire logic data_ready,
	output logic row_marker,
	output logic frame_active,
	output logic ck_int,
	output logic [ADC_W-1:0] adc_word,
	output logic adc_strobe
);
	logic rst_a_reg, rst_b_reg, rst_sync_n;
	logic sync_a_reg, sync_b_reg, sync_d_reg;
	logic [3:0] div_reg;
	logic ck_int_reg;
	seq_state_t state_reg, state_next;
	logic [8:0] line_reg;
	logic [6:0] col_reg;
	logic [2:0] sub_reg;
	logic first_reg;
	logic [PIX_W-1:0] m0_reg, m1_reg;
	logic [SUBFRAMES*PIX_W-1:0] pix_reg;
	logic [5:0] addr_col_reg;
	logic [8:0] addr_row_reg;
	logic raw_rst_n;
	logic int_fall, sync_fell, fifo_ready;
	logic advance, sub_end, col_end, line_end, frame_end;
	logic [PIX_W-1:0] b0_pix, b1_pix;
	logic [WORD_W+PIX_W-1:0] push_word, pop_word;
	logic pop_valid, take;

	// Any of the three reset sources clears the logic
	assign raw_rst_n = rst_n && reset_pad_n && por_n;

	// Reset release through two stages; assertion stays immediate, but
	// release lands on one clean edge for every flop behind it
	always_ff @(posedge mclk or negedge raw_rst_n) begin
		if (!raw_rst_n) begin
			rst_a_reg <= 1'b0;
			rst_b_reg <= 1'b0;
		end else begin
			rst_a_reg <= 1'b1;
			rst_b_reg <= rst_a_reg;
		end
	end
	assign rst_sync_n = rst_b_reg;

	// Divide by ten, free running; falling edge at count four
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			div_reg <= '0;
			ck_int_reg <= 1'b1;
		end else begin
			div_reg <= (div_reg == DIV_LAST) ? 4'h0 : div_reg + 4'h1;
			if (div_reg == DIV_LAST)
				ck_int_reg <= 1'b1;
			else if (div_reg == DIV_FALL)
				ck_int_reg <= 1'b0;
		end
	end
	assign int_fall = (div_reg == DIV_FALL);
	assign ck_int = ck_int_reg;

	// Sync pin: two stages, then a latch sampled only on internal edges
	// A token shorter than one internal period may go unseen
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			sync_a_reg <= 1'b0;
			sync_b_reg <= 1'b0;
			sync_d_reg <= 1'b0;
		end else begin
			sync_a_reg <= sync_in;
			sync_b_reg <= sync_a_reg;
			if (int_fall)
				sync_d_reg <= sync_b_reg;
		end
	end
	// Falling edge seen by the internal clock sampling
	assign sync_fell = int_fall && sync_d_reg && !sync_b_reg;

	// Scan counters: sub slot fastest, then column, then line
	assign advance = (state_reg == ST_RUN) && int_fall && fifo_ready;
	assign sub_end = (sub_reg == SUB_LAST);
	assign col_end = (col_reg == COL_LAST);
	assign line_end = (line_reg == LINE_LAST);
	assign frame_end = sub_end && col_end && line_end;

	// Idle until the first sync; afterwards runs freely
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: if (sync_fell) state_next = ST_RUN;
			ST_ARM: state_next = ST_RUN;
			ST_RUN: state_next = ST_RUN;
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	// Counter update; a new sync restarts at frame origin. Restart wins
	// over a scan step in the same cycle, so no counter is left half moved
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			line_reg <= '0;
			col_reg <= '0;
			sub_reg <= '0;
			first_reg <= 1'b0;
		end else if (sync_fell) begin
			line_reg <= '0;
			col_reg <= '0;
			sub_reg <= '0;
			first_reg <= 1'b1;
		end else if (advance) begin
			sub_reg <= sub_end ? 3'h0 : sub_reg + 3'h1;
			if (sub_end) begin
				col_reg <= col_end ? 7'h00 : col_reg + 7'h01;
				if (col_end)
					line_reg <= line_end ? 9'h000 : line_reg + 9'h001;
			end
			if (frame_end)
				first_reg <= 1'b1;
			else if (sub_end && col_reg == COL_FIRST_PIX)
				first_reg <= 1'b0;
		end
	end

	// Columns ahead of the first real pixel carry the row stamp
	function automatic logic stamp_col(input logic [6:0] c);
		return c < COL_FIRST_PIX;
	endfunction

	// Marker levels and pixel sample taken every cycle
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			m0_reg <= MARK0_RST;
			m1_reg <= MARK1_RST;
			pix_reg <= '0;
			addr_col_reg <= '0;
			addr_row_reg <= '0;
		end else begin
			m0_reg <= mark0_level; // taken from the mark0_level pins
			m1_reg <= mark1_level;
			pix_reg <= pixel_in;
			addr_row_reg <= line_reg;
			addr_col_reg <= stamp_col(col_reg) ? 6'h00 :
				6'(col_reg - COL_FIRST_PIX);
		end
	end
	assign row_addr = addr_row_reg;
	assign col_addr = addr_col_reg;

	// Per bank pixel select: slots 0..4 bank 0, 5..9 bank 1
	function automatic logic [PIX_W-1:0] pick(
		input logic [SUBFRAMES*PIX_W-1:0] v, input int idx);
		pick = v[idx*PIX_W +: PIX_W];
	endfunction
	// Marker columns replace data at the start of each row; one
	// selector per bank, bank k reading slots 5k to 5k+4
	logic [PIX_W-1:0] bank_pix [BANKS];
	for (genvar gb = 0; gb < BANKS; gb++) begin : g_bank
		assign bank_pix[gb] = (col_reg == 7'h00) ? m0_reg :
			(col_reg == 7'h01) ? m1_reg :
			pick(pix_reg, int'(sub_reg) + gb * SUB_PER_BANK);
	end
	assign b0_pix = bank_pix[0];
	assign b1_pix = bank_pix[1];
	// First flag set only on the real first pixel of a frame
	assign push_word = {first_reg && line_reg == 9'h000 &&
		col_reg == COL_FIRST_PIX && sub_reg == 3'h0,
		stamp_col(col_reg), sub_reg, b0_pix, b1_pix};

	// Bank data registers; both banks travel in one buffer word so that
	// they can never drift apart under back pressure
	logic [PIX_W-1:0] b0_out_reg, b1_out_reg;
	logic first_out_reg, row_out_reg, valid_out_reg;
	logic [2:0] slot_out_reg;

	frame_fifo #(
		.WIDTH(WORD_W + PIX_W),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.clk(mclk),
		.rst_n(rst_sync_n),
		.flush(sync_fell),
		.in_data(push_word),
		.in_valid(advance),
		.in_ready(fifo_ready),
		.out_data(pop_word),
		.out_valid(pop_valid),
		.out_ready(data_ready)
	);

	// A word leaves the buffer when the consumer takes it. Back pressure
	// stalls the scan instead of dropping words, so a long stall
	// stretches the frame rather than corrupting it
	assign take = pop_valid && data_ready;

	// Output registers; marker asserts with first pixel data
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			b0_out_reg <= '0;
			b1_out_reg <= '0;
			first_out_reg <= 1'b0;
			row_out_reg <= 1'b0;
			slot_out_reg <= '0;
			valid_out_reg <= 1'b0;
		end else begin
			valid_out_reg <= take;
			if (take) begin
				b0_out_reg <= pop_word[2*PIX_W-1:PIX_W];
				b1_out_reg <= pop_word[PIX_W-1:0];
				first_out_reg <= pop_word[WORD_W+PIX_W-1];
				row_out_reg <= pop_word[WORD_W+PIX_W-2];
				slot_out_reg <= pop_word[2*PIX_W+2:2*PIX_W];
			end else
				first_out_reg <= 1'b0;
		end
	end
	assign bank0_data = b0_out_reg;
	assign bank1_data = b1_out_reg;
	assign first_pixel_marker = first_out_reg;
	assign row_marker = row_out_reg;
	assign bank_slot = slot_out_reg;
	assign data_valid = valid_out_reg;
	assign frame_active = (state_reg == ST_RUN);

	test_converter u_adc (
		.clk(mclk),
		.rst_n(rst_sync_n),
		.sample_in(adc_in),
		.conv_word(adc_word),
		.conv_strobe(adc_strobe)
	);
endmodule // pixel_matrix_readout_sequencer
`default_nettype wire

// >>> shared/readout_pkg.sv
package readout_pkg;
	// Clock and internal sequencing
	localparam int MCLK_HZ = 20000000;
	localparam int CLK_DIV = 10;
	localparam logic [3:0] DIV_LAST = 4'h9;
	localparam logic [3:0] DIV_FALL = 4'h4;
	// Array geometry
	localparam int SUBFRAMES = 10;
	localparam int LINES = 320;
	localparam int COLS = 64;
	localparam int MARKERS = 2;
	localparam int BANKS = 2;
	localparam int SUB_PER_BANK = 5;
	localparam logic [8:0] LINE_LAST = 9'h13f;
	localparam logic [6:0] COL_LAST = 7'h41;
	localparam logic [6:0] COL_FIRST_PIX = 7'h02;
	localparam logic [2:0] SUB_LAST = 3'h4;
	// Pixel data width
	localparam int PIX_W = 8;
	// Test converter
	localparam int ADC_W = 8;
	localparam int ADC_PERIOD_US = 10;
	localparam int ADC_CYCLES = ADC_PERIOD_US * (MCLK_HZ / 1000000);
	localparam logic [7:0] ADC_LAST = 8'(ADC_CYCLES - 1);
	// Output FIFO
	localparam int FIFO_DEPTH = 32;
	localparam int FIFO_AW = 5;
	localparam int WORD_W = 1 + 1 + 3 + PIX_W;
	// Marker defaults
	localparam logic [PIX_W-1:0] MARK0_RST = 8'hff;
	localparam logic [PIX_W-1:0] MARK1_RST = 8'h00;
	typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_RUN} seq_state_t;
endpackage

// >>> core/frame_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module frame_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 32,
	parameter int AW = 5
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic flush,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_reg, rd_reg, count;
	logic [WIDTH-1:0] dout_reg;
	logic dvalid_reg;
	logic push, pop, load;
	// Count includes nothing held in the output register
	assign count = wr_reg - rd_reg;
	assign in_ready = (count != (AW+1)'(DEPTH));
	assign push = in_valid && in_ready;
	assign load = (count != '0) && (!dvalid_reg || out_ready);
	assign pop = load;
	assign out_valid = dvalid_reg;
	assign out_data = dout_reg;

	// Storage array, written only
	always_ff @(posedge clk) begin
		if (push)
			mem[wr_reg[AW-1:0]] <= in_data;
	end

	// Pointers and registered read port
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_reg <= '0;
			rd_reg <= '0;
			dvalid_reg <= 1'b0;
			dout_reg <= '0;
		end else if (flush) begin
			wr_reg <= '0;
			rd_reg <= '0;
			dvalid_reg <= 1'b0;
		end else begin
			if (push)
				wr_reg <= wr_reg + 1'b1;
			if (pop) begin
				rd_reg <= rd_reg + 1'b1;
				dout_reg <= mem[rd_reg[AW-1:0]];
				dvalid_reg <= 1'b1;
			end else if (out_ready)
				dvalid_reg <= 1'b0;
		end
	end
endmodule // frame_fifo
`default_nettype wire

// >>> core/test_converter.sv
`timescale 1ns/1ns
`default_nettype none
module test_converter
	import readout_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [ADC_W-1:0] sample_in,
	output logic [ADC_W-1:0] conv_word,
	output logic conv_strobe
);
	logic [7:0] tick_reg;
	logic [ADC_W-1:0] word_reg;
	logic strobe_reg;
	logic tick_end;
	assign tick_end = (tick_reg == ADC_LAST);
	assign conv_word = word_reg;
	assign conv_strobe = strobe_reg;

	// One word every ten microseconds
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_reg <= '0;
			word_reg <= '0;
			strobe_reg <= 1'b0;
		end else begin
			tick_reg <= tick_end ? 8'h00 : tick_reg + 8'h01;
			strobe_reg <= tick_end;
			if (tick_end)
				word_reg <= sample_in;
		end
	end
endmodule // test_converter
`default_nettype wire

// >>> testbench/readout_checker.sv
`timescale 1ns/1ns
`default_nettype none
module readout_checker
	import readout_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic reset_pad_n,
	input wire logic por_n,
	input wire logic [8:0] row_addr,
	input wire logic [5:0] col_addr,
	input wire logic [2:0] bank_slot,
	input wire logic first_pixel_marker,
	input wire logic data_valid,
	input wire logic row_marker,
	input wire logic frame_active,
	input wire logic ck_int,
	input wire logic adc_strobe
);
	logic last_mark_reg;
	// Any of the three reset sources aborts every check
	wire logic any_rst_n = rst_n & reset_pad_n & por_n;
	default clocking @(posedge mclk); endclocking
	default disable iff (!any_rst_n);
	// Kind of the last word out, so pixels can be seen to follow a stamp
	always_ff @(posedge mclk or negedge any_rst_n) begin
		if (!any_rst_n)
			last_mark_reg <= 1'b0;
		else if (data_valid)
			last_mark_reg <= row_marker;
	end
	AST_CK_PERIOD: assert property ($fell(ck_int) |-> ##10 $fell(ck_int))
		else $error("divided clock period wrong");
	AST_ADC_PERIOD: assert property (adc_strobe |-> ##200 adc_strobe)
		else $error("converter word spacing wrong");
	AST_FPM_PLACE: assert property (
		first_pixel_marker |-> data_valid && !row_marker
		&& row_addr == 9'h000 && col_addr == 6'h00 && bank_slot == 3'h0)
		else $error("frame marker off the first pixel");
	AST_FPM_PULSE: assert property (
		first_pixel_marker |=> !first_pixel_marker)
		else $error("frame marker longer than one cycle");
	AST_QUIET_IDLE: assert property (!frame_active |-> !data_valid)
		else $error("data before readout started");
	AST_START_EDGE: assert property ($rose(frame_active) |-> !ck_int)
		else $error("readout started off the falling edge");
	AST_ROW_STAMP: assert property (
		data_valid && !row_marker && col_addr == 6'h00 && bank_slot == 3'h0
		|-> last_mark_reg)
		else $error("row pixels without stamp ahead");
	AST_ADDR_RANGE: assert property (
		data_valid |-> row_addr <= LINE_LAST && bank_slot <= SUB_LAST)
		else $error("scan address out of range");
	COV_FRAME: cover property (first_pixel_marker);
	COV_ADC: cover property (adc_strobe);
	COV_MARK: cover property (data_valid && row_marker);
endmodule // readout_checker
bind pixel_matrix_readout_sequencer readout_checker chk_u (.mclk(mclk),
	.rst_n(rst_n), .reset_pad_n(reset_pad_n), .por_n(por_n),
	.row_addr(row_addr), .col_addr(col_addr), .bank_slot(bank_slot),
	.first_pixel_marker(first_pixel_marker), .data_valid(data_valid),
	.row_marker(row_marker), .frame_active(frame_active), .ck_int(ck_int),
	.adc_strobe(adc_strobe));
`default_nettype wire

// >>> testbench/sync_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module sync_ctrl (
	input wire logic mclk,
	input wire logic start,
	output logic sync_in
);
	int hold = 0;
	logic token_reg = 1'b0;
	assign sync_in = token_reg;
	// Token held long enough for the slow internal clock to catch it
	always @(posedge mclk) begin
		if (start) begin
			hold <= 30;
			token_reg <= 1'b1;
		end else if (hold > 1) begin
			hold <= hold - 1;
		end else if (hold == 1) begin
			hold <= 0;
			token_reg <= 1'b0;
		end
	end
endmodule // sync_ctrl
`default_nettype wire

// >>> testbench/pixel_matrix_readout_sequencer_test.sv
`timescale 1ns/1ns
`default_nettype none
module pixel_matrix_readout_sequencer_test
	import readout_pkg::*;
;
	logic mclk, rst_n, reset_pad_n, por_n, start, data_ready, sync_in;
	logic [PIX_W-1:0] mark0, mark1, bank0_data, bank1_data;
	logic [SUBFRAMES*PIX_W-1:0] pixel_in;
	logic [ADC_W-1:0] adc_in, adc_word;
	logic [8:0] row_addr;
	logic [5:0] col_addr;
	logic [2:0] bank_slot;
	logic first_pixel_marker, data_valid, row_marker, frame_active;
	logic ck_int, adc_strobe;
	int fails = 0;
	int n_compared = 0;
	sync_ctrl ctrl_u (.mclk(mclk), .start(start), .sync_in(sync_in));
	pixel_matrix_readout_sequencer dut_u (.mclk(mclk), .rst_n(rst_n),
		.reset_pad_n(reset_pad_n), .por_n(por_n), .sync_in(sync_in),
		.mark0_level(mark0), .mark1_level(mark1), .pixel_in(pixel_in),
		.adc_in(adc_in), .row_addr(row_addr), .col_addr(col_addr),
		.bank0_data(bank0_data), .bank1_data(bank1_data),
		.bank_slot(bank_slot), .first_pixel_marker(first_pixel_marker),
		.data_valid(data_valid), .data_ready(data_ready),
		.row_marker(row_marker), .frame_active(frame_active),
		.ck_int(ck_int), .adc_word(adc_word), .adc_strobe(adc_strobe));
	// Stand-in for the controller's readout clock
	always #25 mclk = ~mclk;
	function automatic logic [7:0] pix(input int k);
		return 8'h10 + 8'(k);
	endfunction
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Next output word; a missing word ends the run
	task automatic next_word();
		int i;
		i = 0;
		@(negedge mclk);
		while (data_valid !== 1'b1 && i < 400) begin
			@(negedge mclk);
			i++;
		end
		if (data_valid !== 1'b1) begin
			fails++;
			wrap_up();
		end
	endtask
	task automatic pulse_sync();
		start = 1'b1;
		@(negedge mclk);
		start = 1'b0;
	endtask
	// Start a frame, walk the row stamp and the first pixel of each slot
	task automatic t_start();
		int n;
		n = 0;
		pulse_sync();
		next_word();
		while (first_pixel_marker !== 1'b1 && n < 20) begin
			chk({row_marker, bank0_data}, {1'b1, (n < 5) ? mark0 : mark1});
			n++;
			next_word();
		end
		chk(19'(n), 19'h0000a);
		chk({row_addr, col_addr}, 19'h00000);
		for (int s = 0; s < 5; s++) begin
			if (s > 0)
				next_word();
			chk({bank_slot, bank0_data, bank1_data},
				{3'(s), pix(s), pix(s + 5)});
		end
	endtask
	// Stall past the buffer depth; the scan must hold, then resume with
	// nothing lost and both banks still paired
	task automatic t_stall();
		logic [5:0] held;
		data_ready = 1'b0;
		repeat (400) @(negedge mclk);
		held = col_addr;
		repeat (50) @(negedge mclk);
		chk(col_addr, held);
		data_ready = 1'b1;
		for (int i = 0; i < 60; i++) begin
			next_word();
			chk({bank_slot, row_marker, bank0_data, bank1_data},
				{3'(i % 5), 1'b0, pix(i % 5), pix(i % 5 + 5)});
		end
	endtask
	// Resync mid-row must bring back the frame's first pixel
	task automatic t_resync();
		int n;
		n = 0;
		pulse_sync();
		next_word();
		while (first_pixel_marker !== 1'b1 && n < 60) begin
			n++;
			next_word();
		end
		chk({row_addr, col_addr, bank0_data}, {15'h0000, pix(0)});
	endtask
	task automatic wait_adc(output int i);
		i = 0;
		do begin
			@(negedge mclk);
			i++;
		end while (adc_strobe !== 1'b1 && i < 250);
		if (adc_strobe !== 1'b1) begin
			fails++;
			wrap_up();
		end
	endtask
	task automatic t_adc();
		int i;
		wait_adc(i);
		chk(19'(adc_word), 19'h0005a);
		wait_adc(i);
		chk(19'(i), 19'h000c8);
	endtask
	// Pad or power-on reset stops readout; a new sync then reads out again
	task automatic t_pad(input logic pad);
		if (pad)
			reset_pad_n = 1'b0;
		else
			por_n = 1'b0;
		repeat (3) @(negedge mclk);
		chk({frame_active, data_valid}, 19'h00000);
		reset_pad_n = 1'b1;
		por_n = 1'b1;
		repeat (4) @(negedge mclk);
		t_start();
	endtask
	initial begin
		mclk = 1'b0;
		rst_n = 1'b0;
		reset_pad_n = 1'b1;
		por_n = 1'b1;
		start = 1'b0;
		data_ready = 1'b1;
		mark0 = 8'ha5; // readout settings loaded before any sync
		mark1 = 8'h3c;
		adc_in = 8'h5a;
		for (int k = 0; k < SUBFRAMES; k++)
			pixel_in[8*k +: 8] = pix(k);
		repeat (16) @(negedge mclk);
		rst_n = 1'b1;
		repeat (3) @(negedge mclk);
		t_start();
		t_stall();
		t_resync();
		t_adc();
		t_pad(1'b1);
		t_pad(1'b0);
		wrap_up();
	end
endmodule // pixel_matrix_readout_sequencer_test
`default_nettype wire
